// *** amrx_pkg.sv ***
package amrx_pkg;
  // Configuration word layout
  localparam int AMRX_CFG_W = 24;
  localparam int AMRX_STEP_W = 20;
  localparam int AMRX_STEP_LSB = 0;
  localparam int AMRX_GAIN_W = 3;
  localparam int AMRX_GAIN_LSB = 20;
  localparam int AMRX_GAIN_MAXSH = 5;
  localparam int AMRX_CNT_W = 5;
  // Audio sample and envelope widths
  localparam int AMRX_ENV_W = 8;
  localparam int AMRX_LEAK_SH = 4;
  localparam int AMRX_DEC_W = 8;
  localparam int AMRX_PWM_W = 8;
  localparam int AMRX_BUF_DEPTH = 2;
  // Reset values
  localparam logic [AMRX_CFG_W-1:0] AMRX_CFG_RST = 24'h000000;

  typedef logic [AMRX_STEP_W-1:0] amrx_step_t;
  typedef logic [AMRX_GAIN_W-1:0] amrx_gain_t;

  // Decoded configuration carried together
  typedef struct packed {
    amrx_gain_t gain;
    amrx_step_t oscillator_step;
  } amrx_cfg_s;

  typedef enum logic {AMRX_PWM_LOAD, AMRX_PWM_RUN} amrx_pwm_e;
endpackage

// *** amrx_radio.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// [R1] Frequency and gain are set only via one 24-bit serial shift register.
// [R2] Bit 23 ignored, bits 22..20 gain code, bits 19..0 oscillator step.
// [R3] Gain codes 0..4 scale by 1,2,4,8,16; codes 5..7 scale by 32.
// [R4] Every clock the oscillator phase accumulator adds the programmed step.
// [R5] Input is a one-bit sample stream from an external comparator.
// [R6] Bandpass mixing by the oscillator, then envelope detection, recovers audio.
// [R7] Excessive gain wraps the scaled value modulo its width, no saturation.
// [R8] Shift MSB first on rising serial clock while select low; commit on select high.
module amrx_radio
  import amrx_pkg::*;
(
  input wire logic clk_sys, // 50 MHz system clock
  input wire logic resetn, // Async active-low reset
  input wire logic comp_in, // Comparator sample bit
  input wire logic spi_mosi, // Serial config data
  input wire logic spi_sck, // Serial config clock
  input wire logic spi_cs_n, // Serial select, active low
  output logic comp_out, // Comparator feedback bit
  output logic pwm_out // Audio PWM
);

  ////////////////////////////////////////////////////////////////////////
  // Reset release and input synchronisers
  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic [3:0] sync1_reg, sync2_reg;
  logic sck_last_reg;
  logic comp_s, mosi_s, sck_s, cs_n_s;

  // Release reset through two flops
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // Two-flop synchronisers for all pins
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= 4'h8;
      sync2_reg <= 4'h8;
      sck_last_reg <= 1'b0;
    end else begin
      sync1_reg <= {spi_cs_n, spi_sck, spi_mosi, comp_in};
      sync2_reg <= sync1_reg;
      sck_last_reg <= sync2_reg[2];
    end
  end
  assign comp_s = sync2_reg[0]; // see [R5]
  assign mosi_s = sync2_reg[1];
  assign sck_s = sync2_reg[2];
  assign cs_n_s = sync2_reg[3];

  ////////////////////////////////////////////////////////////////////////
  // Configuration shift register
  logic [AMRX_CFG_W-1:0] shift_reg, shift_next;
  amrx_cfg_s cfg_reg, cfg_next;
  logic cs_last_reg, cs_last_next;

  // Shift on rising serial clock, commit on select rising
  always_comb begin
    shift_next = shift_reg;
    cfg_next = cfg_reg;
    cs_last_next = cs_n_s;
    if (!cs_n_s && sck_s && !sck_last_reg) begin
      shift_next = {shift_reg[AMRX_CFG_W-2:0], mosi_s}; // see [R8] see [R1]
    end
    if (cs_n_s && !cs_last_reg) begin
      cfg_next.gain = shift_reg[AMRX_GAIN_LSB +: AMRX_GAIN_W]; // see [R2]
      cfg_next.oscillator_step = shift_reg[AMRX_STEP_LSB +: AMRX_STEP_W]; // see [R2]
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= AMRX_CFG_RST;
      cfg_reg <= AMRX_CFG_RST[AMRX_GAIN_LSB+AMRX_GAIN_W-1:0];
      cs_last_reg <= 1'b1;
    end else begin
      shift_reg <= shift_next;
      cfg_reg <= cfg_next;
      cs_last_reg <= cs_last_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Oscillator, mixer and envelope detector
  function automatic logic [AMRX_CNT_W-1:0] amrx_gain_shift(input amrx_gain_t code);
    if (code > amrx_gain_t'(AMRX_GAIN_MAXSH - 1)) begin
      amrx_gain_shift = AMRX_CNT_W'(AMRX_GAIN_MAXSH);
    end else begin
      amrx_gain_shift = AMRX_CNT_W'(code);
    end
  endfunction

  // Leaky integrator step; arithmetic leak keeps negative sums from running away
  function automatic logic [AMRX_ENV_W-1:0] amrx_integrate(input logic [AMRX_ENV_W-1:0] acc, input logic up);
    logic signed [AMRX_ENV_W-1:0] acc_s;
    logic [AMRX_ENV_W-1:0] leak;
    acc_s = acc;
    leak = acc_s >>> AMRX_LEAK_SH;
    amrx_integrate = acc - leak + (up ? AMRX_ENV_W'(1) : -AMRX_ENV_W'(1));
  endfunction

  // Magnitude of a two's complement sum
  function automatic logic [AMRX_ENV_W-1:0] amrx_abs(input logic [AMRX_ENV_W-1:0] val);
    amrx_abs = val[AMRX_ENV_W-1] ? -val : val;
  endfunction

  amrx_step_t phase_reg, phase_next;
  logic [AMRX_ENV_W-1:0] i_acc_reg, i_acc_next, q_acc_reg, q_acc_next;
  logic [AMRX_ENV_W-1:0] env_reg, env_next;
  logic [AMRX_DEC_W-1:0] dec_reg, dec_next;
  logic smp_valid_reg, smp_valid_next;
  logic [AMRX_PWM_W-1:0] smp_reg, smp_next;
  logic buf_ready;
  logic i_mix, q_mix;
  logic [AMRX_ENV_W-1:0] i_abs, q_abs, mag;

  // Mix the one-bit input with quadrature oscillator, leaky integrate
  always_comb begin
    phase_next = phase_reg + cfg_reg.oscillator_step; // see [R4]
    i_mix = comp_s ^ phase_reg[AMRX_STEP_W-1]; // see [R6]
    q_mix = comp_s ^ phase_reg[AMRX_STEP_W-1] ^ phase_reg[AMRX_STEP_W-2];
    i_acc_next = amrx_integrate(i_acc_reg, i_mix); // see [R6]
    q_acc_next = amrx_integrate(q_acc_reg, q_mix);
    i_abs = amrx_abs(i_acc_reg);
    q_abs = amrx_abs(q_acc_reg);
    mag = (i_abs > q_abs) ? i_abs : q_abs;
    // Peak follower with slow decay
    env_next = (mag > env_reg) ? mag : env_reg - AMRX_ENV_W'(env_reg != '0 && dec_reg == '0); // see [R6]
    dec_next = dec_reg + AMRX_DEC_W'(1);
    smp_valid_next = smp_valid_reg;
    smp_next = smp_reg;
    if (smp_valid_reg && buf_ready) begin
      smp_valid_next = 1'b0;
    end
    if (dec_reg == '0 && !(smp_valid_reg && !buf_ready)) begin
      smp_valid_next = 1'b1;
      smp_next = AMRX_PWM_W'(env_reg << amrx_gain_shift(cfg_reg.gain)); // see [R3] see [R7]
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= '0;
      i_acc_reg <= '0;
      q_acc_reg <= '0;
      env_reg <= '0;
      dec_reg <= '0;
      smp_valid_reg <= 1'b0;
      smp_reg <= '0;
    end else begin
      phase_reg <= phase_next;
      i_acc_reg <= i_acc_next;
      q_acc_reg <= q_acc_next;
      env_reg <= env_next;
      dec_reg <= dec_next;
      smp_valid_reg <= smp_valid_next;
      smp_reg <= smp_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Two-entry sample buffer and PWM drain
  logic [AMRX_PWM_W-1:0] buf_mem_reg [AMRX_BUF_DEPTH], buf_mem_next [AMRX_BUF_DEPTH];
  logic wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [1:0] buf_cnt_reg, buf_cnt_next;
  logic buf_valid, pwm_ready, buf_push, buf_pop;
  amrx_pwm_e pwm_state_reg, pwm_state_next;
  logic [AMRX_PWM_W-1:0] pwm_cnt_reg, pwm_cnt_next, duty_reg, duty_next;
  logic pwm_reg, pwm_next, comp_out_reg;

  assign buf_ready = (buf_cnt_reg != 2'(AMRX_BUF_DEPTH));
  assign buf_valid = (buf_cnt_reg != 2'h0);

  // Buffer pointers and PWM period engine
  always_comb begin
    buf_mem_next = buf_mem_reg;
    pwm_ready = 1'b0;
    pwm_state_next = pwm_state_reg;
    pwm_cnt_next = pwm_cnt_reg + AMRX_PWM_W'(1);
    duty_next = duty_reg;
    unique case (pwm_state_reg)
      AMRX_PWM_LOAD: begin
        pwm_ready = 1'b1;
        if (buf_valid) begin
          pwm_state_next = AMRX_PWM_RUN;
          duty_next = buf_mem_reg[rd_ptr_reg];
          pwm_cnt_next = '0;
        end
      end
      AMRX_PWM_RUN: begin
        if (pwm_cnt_reg == '1) begin
          pwm_state_next = AMRX_PWM_LOAD;
        end
      end
    endcase
    buf_push = smp_valid_reg && buf_ready;
    buf_pop = buf_valid && pwm_ready;
    if (buf_push) begin
      buf_mem_next[wr_ptr_reg] = smp_reg;
    end
    wr_ptr_next = wr_ptr_reg ^ buf_push;
    rd_ptr_next = rd_ptr_reg ^ buf_pop;
    buf_cnt_next = buf_cnt_reg + 2'(buf_push) - 2'(buf_pop);
    pwm_next = (pwm_state_reg == AMRX_PWM_RUN) && (pwm_cnt_reg < duty_reg);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      buf_mem_reg <= '{default: '0};
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      buf_cnt_reg <= 2'h0;
      pwm_state_reg <= AMRX_PWM_LOAD;
      pwm_cnt_reg <= '0;
      duty_reg <= '0;
      pwm_reg <= 1'b0;
      comp_out_reg <= 1'b0;
    end else begin
      buf_mem_reg <= buf_mem_next;
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      buf_cnt_reg <= buf_cnt_next;
      pwm_state_reg <= pwm_state_next;
      pwm_cnt_reg <= pwm_cnt_next;
      duty_reg <= duty_next;
      pwm_reg <= pwm_next;
      comp_out_reg <= comp_s;
    end
  end

  assign pwm_out = pwm_reg;
  assign comp_out = comp_out_reg;

endmodule

// *** amrx_radio_assertions.sv ***
`timescale 1ns/1ps
module amrx_radio_checker
  import amrx_pkg::*;
(
  input wire logic clk_sys, // System clock
  input wire logic resetn, // Reset, active low
  input wire logic comp_in, // Comparator bit
  input wire logic spi_mosi, // Serial data
  input wire logic spi_sck, // Serial clock
  input wire logic spi_cs_n, // Serial select
  input wire logic comp_out, // Comparator echo
  input wire logic pwm_out // Audio PWM
);
  logic [3:0] up_reg; // Cycles since release
  logic [8:0] hi_reg; // PWM high run
  // Settle counter and PWM high run length
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      up_reg <= 4'h0;
      hi_reg <= 9'h000;
    end else begin
      up_reg <= (up_reg == 4'hF) ? up_reg : up_reg + 4'h1;
      hi_reg <= pwm_out ? hi_reg + 9'h001 : 9'h000;
    end
  end
  property p_echo;
    @(posedge clk_sys) disable iff (!resetn) (up_reg > 4'h5) |-> comp_out == $past(comp_in, 3);
  endproperty
  a_echo: assert property (p_echo) else $error("comparator echo delay wrong");
  property p_echo_rise;
    @(posedge clk_sys) disable iff (!resetn) (up_reg > 4'h5) && $rose(comp_in) |-> ##3 comp_out;
  endproperty
  a_echo_rise: assert property (p_echo_rise) else $error("comparator rise not echoed");
  property p_echo_fall;
    @(posedge clk_sys) disable iff (!resetn) (up_reg > 4'h5) && $fell(comp_in) |-> ##3 !comp_out;
  endproperty
  a_echo_fall: assert property (p_echo_fall) else $error("comparator fall not echoed");
  property p_pwm_rst;
    @(posedge clk_sys) disable iff (1'b0) !resetn |-> !pwm_out;
  endproperty
  a_pwm_rst: assert property (p_pwm_rst) else $error("pwm high in reset");
  property p_comp_rst;
    @(posedge clk_sys) disable iff (1'b0) !resetn |-> !comp_out;
  endproperty
  a_comp_rst: assert property (p_comp_rst) else $error("echo high in reset");
  property p_pwm_run;
    @(posedge clk_sys) disable iff (!resetn) hi_reg < 9'h100;
  endproperty
  a_pwm_run: assert property (p_pwm_run) else $error("pwm high too long");
endmodule
bind amrx_radio amrx_radio_checker i_amrx_radio_checker (.clk_sys(clk_sys), .resetn(resetn),
  .comp_in(comp_in), .spi_mosi(spi_mosi), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
  .comp_out(comp_out), .pwm_out(pwm_out));

// *** amrx_comp_model.sv ***
`timescale 1ns/1ps
module amrx_comp_model (
  input wire logic en, // Carrier present
  input wire logic lvl, // Level held without carrier
  output logic comp_in // Comparator bit
);
  // Square carrier, or a steady level, phase kept off the clock grid
  initial begin
    comp_in = 1'b0;
    #1.35;
    forever begin
      #26.7;
      comp_in = en ? ~comp_in : lvl;
    end
  end
endmodule

// *** amrx_tb.sv ***
`timescale 1ns/1ps
module tb;
  import amrx_pkg::*;
  logic clk_sys = 1'b0;
  localparam int PWM_PERIOD = 257; // Load cycle plus full count
  localparam int SETTLE_CYC = 6 * PWM_PERIOD;
  localparam int WINDOW_CYC = 4 * PWM_PERIOD;
  logic resetn = 1'b1;
  logic spi_mosi = 1'b0;
  logic spi_sck = 1'b0;
  logic spi_cs_n = 1'b1;
  logic carrier_en = 1'b0;
  logic comp_lvl = 1'b0;
  logic comp_in, comp_out, pwm_out;
  logic [2:0] hist = 3'h0;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;
  int hi_run = 0;
  int hi_cnt = 0;
  int lo_cnt = 0;
  always #10 clk_sys = ~clk_sys;
  amrx_comp_model i_amrx_comp_model (.en(carrier_en), .lvl(comp_lvl), .comp_in(comp_in));
  amrx_radio i_amrx_radio (.clk_sys(clk_sys), .resetn(resetn), .comp_in(comp_in), .spi_mosi(spi_mosi),
    .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .comp_out(comp_out), .pwm_out(pwm_out));
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic clks(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // One frame, MSB first, commit on select high
  task automatic spi_write(input logic [AMRX_CFG_W-1:0] word);
    spi_cs_n <= 1'b0;
    for (int i = AMRX_CFG_W - 1; i >= 0; i--) begin
      spi_mosi <= word[i];
      clks(4);
      spi_sck <= 1'b1;
      clks(4);
      spi_sck <= 1'b0;
    end
    clks(4);
    spi_cs_n <= 1'b1;
    spi_mosi <= ~word[0];
    clks(8);
  endtask
  task automatic reset_checks();
    @(negedge clk_sys);
    check("pwm_out in reset", 1'b0, pwm_out);
    check("comp_out in reset", 1'b0, comp_out);
  endtask
  // Hold the comparator level, set a gain, count PWM cycles over whole periods
  task automatic gain_run(input logic [2:0] g, input logic lvl, input int duty);
    int hi0;
    int lo0;
    comp_lvl <= lvl;
    spi_write({~g[0], g, 20'h00000});
    clks(SETTLE_CYC);
    hi0 = hi_cnt;
    lo0 = lo_cnt;
    clks(WINDOW_CYC);
    check("pwm high cycles", 4 * duty, hi_cnt - hi0);
    check("pwm low cycles", WINDOW_CYC - 4 * duty, lo_cnt - lo0);
    $display("test gain %0d level %0b done", g, lvl);
  endtask
  // Input history, cycle count and timeout
  always @(posedge clk_sys) begin
    hist <= {hist[1:0], comp_in};
    hi_run <= (pwm_out === 1'b1) ? hi_run + 1 : 0;
    hi_cnt <= hi_cnt + int'(pwm_out === 1'b1);
    lo_cnt <= lo_cnt + int'(pwm_out === 1'b0);
    cycles++;
    if (cycles >= 50000) begin
      errors++;
      conclude();
    end
  end
  // Gain table from reset, carrier sweep, then reset and release in mid-run
  initial begin
    resetn <= 1'b0;
    clks(10);
    reset_checks();
    @(posedge clk_sys);
    resetn <= 1'b1;
    clks(4);
    gain_run(3'h0, 1'b0, 1);
    gain_run(3'h1, 1'b0, 2);
    gain_run(3'h2, 1'b0, 4);
    gain_run(3'h3, 1'b0, 8);
    gain_run(3'h4, 1'b0, 16);
    gain_run(3'h5, 1'b0, 32);
    gain_run(3'h6, 1'b0, 32);
    gain_run(3'h7, 1'b0, 32);
    gain_run(3'h3, 1'b1, 128);
    gain_run(3'h4, 1'b1, 0);
    gain_run(3'h5, 1'b1, 0);
    for (int g = 0; g < 8; g++) begin
      spi_write({g[0], g[2:0], 20'h02767});
      carrier_en <= 1'b1;
      clks(6);
      repeat (600) begin
        @(negedge clk_sys);
        check("comp_out echo", hist[2], comp_out);
        check("pwm high run", 1'b1, hi_run < 256);
      end
      @(posedge clk_sys);
      $display("test gain %0d done", g);
    end
    @(posedge clk_sys);
    resetn <= 1'b0;
    clks(3);
    reset_checks();
    @(posedge clk_sys);
    resetn <= 1'b1;
    clks(6);
    repeat (50) begin
      @(negedge clk_sys);
      check("comp_out echo after release", hist[2], comp_out);
    end
    $display("test mid-run reset done");
    conclude();
  end
endmodule
